// ==== tb_top.sv ====
// tb_top: self-checking bench for the timer block
`default_nettype none
`timescale 1ns/1ps
module tb_top
  import tm3_pkg::*;
;
  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writeData;
  logic              writeStrobe;
  logic              readStrobe;
  logic [DATA_W-1:0] readData;
  logic [3:0]        ccpModeField;
  logic              specialTrigger;
  logic [15:0]       counterValue;
  logic              ccpUsesCounter;
  tm3_pins_t         pinIn;
  tm3_pins_t         pinOut;
  tm3_pins_t         pinOe;
  logic              irq;
  int                errTotal;
  int                totalChecks;
  logic [7:0]        rv;
  tm3_timer dut (.clk(clk), .reset(reset), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .ccpModeField(ccpModeField), .specialTrigger(specialTrigger), .counterValue(counterValue),
    .ccpUsesCounter(ccpUsesCounter), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
  tm3_pin_model pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    @(negedge clk);
    v = readData;
    @(posedge clk);
  endtask
  // cycles between two successive counter steps
  task automatic period(output int n);
    logic [15:0] v0;
    @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      v0 = counterValue;
      n = 0;
      while (counterValue === v0 && n < 100) begin
        @(negedge clk);
        n++;
      end
    end
    @(posedge clk);
  endtask
  // one trigger pulse under a given compare mode
  task automatic trig(input logic [3:0] m, input logic [15:0] exp);
    ccpModeField <= m;
    specialTrigger <= 1'b1;
    @(posedge clk);
    specialTrigger <= 1'b0;
    @(negedge clk);
    chk(counterValue, exp);
    @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rv);
      chk(rv, (3'(a) == OFF_PINDIR) ? 16'h0003 : 16'h0000);
    end
    $display("test reset values done");
  endtask
  task automatic t_prescale;
    int n;
    for (int p = 0; p < 4; p++) begin
      wr(OFF_CTRL, 8'h00);
      wr(OFF_CTRL, 8'(p << CTL_PS_LO) | 8'h01);
      period(n);
      chk(16'(n), 16'(1 << p));
    end
    wr(OFF_CTRL, 8'h00);
    @(negedge clk);
    rv = counterValue[7:0];
    repeat (20) @(negedge clk);
    chk(counterValue[7:0], rv);
    @(posedge clk);
    $display("test prescale done");
  endtask
  task automatic t_overflow;
    int n;
    wr(OFF_HIGH, 8'hFF);
    wr(OFF_LOW, 8'hFE);
    wr(OFF_ENABLES, 8'h02);
    wr(OFF_CTRL, 8'h01);
    n = 0;
    while (counterValue !== 16'h0000 && n < 20) begin
      @(posedge clk);
      n++;
    end
    wr(OFF_CTRL, 8'h00);
    rd(OFF_FLAGS, rv);
    chk(rv[FLAG_OVF], 16'h0001);
    chk(irq, 16'h0001);
    wr(OFF_ENABLES, 8'h00);
    @(negedge clk);
    chk(irq, 16'h0000);
    @(posedge clk);
    wr(OFF_ENABLES, 8'h02);
    @(negedge clk);
    chk(irq, 16'h0001);
    @(posedge clk);
    wr(OFF_FLAGS, 8'h02);
    rd(OFF_FLAGS, rv);
    chk(rv, 16'h0000);
    chk(irq, 16'h0000);
    $display("test overflow done");
  endtask
  // trigger clears the counter in special event compare mode only
  task automatic t_trigger;
    wr(OFF_HIGH, 8'h00);
    for (int m = 0; m < 16; m++) begin
      wr(OFF_LOW, 8'h55);
      trig(4'(m), (4'(m) == MODE_SPECIAL) ? 16'h0000 : 16'h0055);
    end
    wr(OFF_HIGH, 8'hFF);
    wr(OFF_LOW, 8'hFE);
    wr(OFF_CTRL, 8'h01);
    trig(MODE_SPECIAL, 16'h0000);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_FLAGS, rv);
    chk(rv, 16'h0000);
    address <= OFF_LOW;
    writeData <= 8'h33;
    writeStrobe <= 1'b1;
    specialTrigger <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
    specialTrigger <= 1'b0;
    @(negedge clk);
    chk(counterValue, 16'h0033);
    @(posedge clk);
    $display("test trigger done");
  endtask
  task automatic t_wide;
    wr(OFF_CTRL, 8'h80);
    wr(OFF_HIGH, 8'h12);
    chk(counterValue, 16'h0033);
    wr(OFF_LOW, 8'h34);
    chk(counterValue, 16'h1234);
    rd(OFF_LOW, rv);
    chk(rv, 16'h0034);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_HIGH, 8'h56);
    chk(counterValue, 16'h5634);
    wr(OFF_CTRL, 8'h80);
    rd(OFF_HIGH, rv);
    chk(rv, 16'h0012);
    wr(OFF_CTRL, 8'h40);
    @(negedge clk);
    chk(ccpUsesCounter, 16'h0001);
    @(posedge clk);
    $display("test wide access done");
  endtask
  task automatic t_extclk;
    wr(OFF_CTRL, 8'h00);
    wr(OFF_HIGH, 8'h00);
    wr(OFF_LOW, 8'h00);
    wr(OFF_CTRL, 8'h03);
    pins.burst(1'b0, 5);
    chk(counterValue, 16'h0004);
    wr(OFF_PINDIR, 8'h00);
    wr(OFF_PINDATA, 8'h03);
    @(negedge clk);
    chk(pinOe, 16'h0003);
    chk(pinOut, 16'h0003);
    repeat (4) @(posedge clk);
    rd(OFF_PINDATA, rv);
    chk(rv, 16'h0003);
    wr(OFF_COMPANION, 8'h08);
    @(negedge clk);
    chk(pinOe, 16'h0000);
    @(posedge clk);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_LOW, 8'h00);
    wr(OFF_CTRL, 8'h07);
    pins.burst(1'b1, 3);
    chk(counterValue, 16'h0002);
    pins.lvl.ext <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFF_PINDATA, rv);
    chk(rv, 16'h0000);
    pins.lvl.ext <= 1'b0;
    $display("test external clock done");
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    results;
  end
  initial begin
    errTotal = 0;
    totalChecks = 0;
    reset = 1'b1;
    address = '0;
    writeData = '0;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    ccpModeField = '0;
    specialTrigger = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_prescale;
    t_overflow;
    t_trigger;
    t_wide;
    t_extclk;
    results;
  end
endmodule
bind tm3_timer tm3_timer_asserts chk_i (.clk(clk), .reset(reset), .address(address),
  .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
  .ccpModeField(ccpModeField), .specialTrigger(specialTrigger), .counterValue(counterValue),
  .ccpUsesCounter(ccpUsesCounter), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
`default_nettype wire

// ==== tm3_edge_sync.sv ====
// tm3_edge_sync: two-flop pin synchroniser with edge detection
`default_nettype none
`timescale 1ns/1ps
module tm3_edge_sync
  import tm3_pkg::*;
#(
  parameter int W = 2                         // number of pins
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pinRaw,           // asynchronous pin levels
  output logic      [W-1:0] pinLevel,         // synchronised levels
  output logic      [W-1:0] pinRise,          // one-cycle rising edge pulse
  output logic      [W-1:0] pinFall           // one-cycle falling edge pulse
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (W < 1) begin : g_bad_w
    $error("tm3_edge_sync: W must be at least one");
  end

  logic [W-1:0] stage1;                       // metastable stage, read only by stage2
  logic [W-1:0] stage2;                       // first stable stage
  logic [W-1:0] stage3;                       // delayed copy for edges

  // ------------------------------------------------------------------
  // synchroniser chain
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinRaw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // edges come from the stable stages only
  assign pinLevel = stage2;
  assign pinRise  = stage2 & ~stage3;
  assign pinFall  = ~stage2 & stage3;

endmodule
`default_nettype wire

// ==== tm3_pin_model.sv ====
// tm3_pin_model: far-side clock sources on the two timer pins
`default_nettype none
`timescale 1ns/1ps
module tm3_pin_model
  import tm3_pkg::*;
(
  input  wire logic      clk,
  input  wire tm3_pins_t pinOut,
  input  wire tm3_pins_t pinOe,
  output var tm3_pins_t  pinIn
);
  tm3_pins_t lvl; // source levels, held low between bursts
  initial lvl = '0;
  // wire level: the block wins while it drives, else the source
  assign pinIn = tm3_pins_t'((pinOe & pinOut) | (~pinOe & lvl));
  // clean clock burst on one pin
  task automatic burst(input logic onOsc, input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      if (onOsc) lvl.osc <= 1'b1;
      else lvl.ext <= 1'b1;
      repeat (4) @(posedge clk);
      if (onOsc) lvl.osc <= 1'b0;
      else lvl.ext <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tm3_pkg.sv ====
// tm3_pkg: shared constants and types for the 16-bit timer/counter block
`default_nettype none
package tm3_pkg;

  // ------------------------------------------------------------------
  // register bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 3;                  // register address width
  localparam int DATA_W = 8;                  // register data width

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 3'h0;  // counter_control
  localparam logic [ADDR_W-1:0] OFF_LOW       = 3'h1;  // counter_low_byte
  localparam logic [ADDR_W-1:0] OFF_HIGH      = 3'h2;  // counter_high_byte
  localparam logic [ADDR_W-1:0] OFF_COMPANION = 3'h3;  // companion_timer_control
  localparam logic [ADDR_W-1:0] OFF_FLAGS     = 3'h4;  // peripheral_flags_b
  localparam logic [ADDR_W-1:0] OFF_ENABLES   = 3'h5;  // peripheral_enables_b
  localparam logic [ADDR_W-1:0] OFF_PINDIR    = 3'h6;  // pin_direction_bits, 1 = input
  localparam logic [ADDR_W-1:0] OFF_PINDATA   = 3'h7;  // pin latch write, pin level read

  // ------------------------------------------------------------------
  // counter_control field positions
  // ------------------------------------------------------------------
  localparam int CTL_ON    = 0;               // counter_on
  localparam int CTL_CS    = 1;               // clock_source_select
  localparam int CTL_NOSYN = 2;               // ext_clock_sync_control
  localparam int CTL_TB_LO = 3;               // compare_timebase_select low bit
  localparam int CTL_PS_LO = 4;               // input_prescale_select [5:4]
  localparam int CTL_TB_HI = 6;               // compare_timebase_select high bit
  localparam int CTL_WIDE  = 7;               // wide_access_mode

  localparam int COMP_OSCEN = 3;              // aux_osc_enable in companion control
  localparam int FLAG_OVF   = 1;              // overflow_flag / overflow_irq_enable

  // ------------------------------------------------------------------
  // values after reset and codes
  // ------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  COMP_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [1:0]  PINDIR_RESET = 2'h3;
  localparam logic [3:0]  MODE_SPECIAL = 4'hB;  // compare, special event trigger

  // pin indices: 0 = shared external clock pin, 1 = oscillator input pin
  localparam int PIN_EXT = 0;
  localparam int PIN_OSC = 1;

  // two-way pin bundle
  typedef struct packed {
    logic osc;                                // oscillator input pin
    logic ext;                                // shared external clock / osc output pin
  } tm3_pins_t;

endpackage
`default_nettype wire

// ==== tm3_timer.sv ====
// tm3_timer: 16-bit timer/counter with prescaler, trigger clear and overflow irq
//
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none
`timescale 1ns/1ps
module tm3_timer
  import tm3_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic [DATA_W-1:0] writeData,
  input  wire logic              writeStrobe,
  input  wire logic              readStrobe,
  output logic      [DATA_W-1:0] readData,
  // capture/compare side
  input  wire logic [3:0]        ccpModeField,
  input  wire logic              specialTrigger,
  output logic      [15:0]       counterValue,
  output logic                   ccpUsesCounter,
  // two-way pins
  input  wire tm3_pins_t         pinIn,
  output tm3_pins_t              pinOut,
  output tm3_pins_t              pinOe,
  // interrupt
  output logic                   irq
);

  // ------------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------------

  // prescale mask: counter ticks when the low prescale bits are all ones
  function automatic logic [2:0] prescaleMask(input logic [1:0] sel);
    logic [2:0] m;
    m = 3'h0;
    case (sel)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      default: m = 3'h7;
    endcase
    return m;
  endfunction

  // address match for a one-cycle strobe
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return strobe && (a == off);
  endfunction

  // ------------------------------------------------------------------
  // registers and internal signals
  // ------------------------------------------------------------------
  logic [7:0]  ctrl;                          // counter_control
  logic [7:0]  companion;                     // companion_timer_control
  logic        ovfFlag;                       // overflow_flag
  logic        ovfEnable;                     // overflow_irq_enable
  logic [1:0]  pinDir;                        // pin_direction_bits, 1 = input
  logic [1:0]  pinLatch;                      // pin output latch
  logic [7:0]  highBuf;                       // wide-mode high byte buffer
  logic [2:0]  psCount;                       // prescaler counter
  logic        armed;                         // first falling edge seen
  logic [1:0]  syncLevel;                     // synchronised pin levels
  logic [1:0]  syncRise;                      // synchronised rising edges
  logic [1:0]  syncFall;                      // synchronised falling edges

  logic        counterOn;
  logic        extSelect;
  logic        wideMode;
  logic        oscEnable;
  logic        srcRise;
  logic        srcFall;
  logic        inputEvent;
  logic        tick;
  logic        wrLow;
  logic        wrHigh;
  logic        wrCtrl;
  logic        counterWrite;
  logic        trigClear;
  logic        overflow;
  logic [2:0]  psMask;
  logic [7:0]  readMux;

  assign counterOn = ctrl[CTL_ON];
  assign extSelect = ctrl[CTL_CS];
  assign wideMode  = ctrl[CTL_WIDE];
  assign oscEnable = companion[COMP_OSCEN];

  assign wrLow  = hit(writeStrobe, address, OFF_LOW);
  assign wrHigh = hit(writeStrobe, address, OFF_HIGH);
  assign wrCtrl = hit(writeStrobe, address, OFF_CTRL);

  // ------------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------------
  // external clock synchronised
  tm3_edge_sync #(
    .W (2)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .pinRaw   ({pinIn.osc, pinIn.ext}),
    .pinLevel (syncLevel),
    .pinRise  (syncRise),
    .pinFall  (syncFall)
  );

  // ------------------------------------------------------------------
  // clock source and prescaler
  // ------------------------------------------------------------------
  // oscillator replaces pin when enabled
  assign srcRise = oscEnable ? syncRise[PIN_OSC] : syncRise[PIN_EXT];
  assign srcFall = oscEnable ? syncFall[PIN_OSC] : syncFall[PIN_EXT];

  // external rising edge after a falling one
  assign inputEvent = extSelect ? (srcRise && armed) : 1'b1;

  assign psMask = prescaleMask(ctrl[CTL_PS_LO +: 2]);
  assign tick   = counterOn && inputEvent && ((psCount & psMask) == psMask);

  // arm on the first falling edge once the external source is chosen
  always_ff @(posedge clk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (!extSelect) begin
      armed <= 1'b0;
    end else if (srcFall) begin
      armed <= 1'b1;
    end
  end

  // prescaler runs on input events, cleared on counter or control writes
  always_ff @(posedge clk) begin
    if (reset) begin
      psCount <= 3'h0;
    end else if (wrLow || wrHigh || wrCtrl || !counterOn) begin
      psCount <= 3'h0;
    end else if (inputEvent) begin
      psCount <= (psCount & psMask) == psMask ? 3'h0 : 3'(psCount + 3'h1);
    end
  end

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  // special event trigger clear
  assign trigClear    = specialTrigger && (ccpModeField == MODE_SPECIAL);
  assign counterWrite = wrLow || (wrHigh && !wideMode);
  // trigger clear, low writes and non-wide high writes never count as overflow
  assign overflow     = tick && !counterWrite && !trigClear && (counterValue == COUNT_MAX);

  // counter update, software write first
  always_ff @(posedge clk) begin
    if (reset) begin
      counterValue <= COUNT_RESET;
    end else if (wrLow) begin
      // low write releases buffered high byte
      counterValue <= wideMode ? {highBuf, writeData} : {counterValue[15:8], writeData};
    end else if (wrHigh && !wideMode) begin
      counterValue <= {writeData, counterValue[7:0]};
    end else if (trigClear) begin
      counterValue <= COUNT_RESET;
    end else if (tick) begin
      counterValue <= 16'(counterValue + 16'h0001);
    end
  end

  // wide-mode buffer: loaded by low read or by high write
  always_ff @(posedge clk) begin
    if (reset) begin
      highBuf <= 8'h00;
    end else if (wrHigh && wideMode) begin
      // high write held until low write
      highBuf <= writeData;
    end else if (hit(readStrobe, address, OFF_LOW) && wideMode) begin
      // low read snapshots live high byte
      highBuf <= counterValue[15:8];
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  // counter and companion control, plain storage
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl      <= CTRL_RESET;
      companion <= COMP_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl <= writeData;
      end
      if (hit(writeStrobe, address, OFF_COMPANION)) begin
        companion <= writeData;
      end
    end
  end

  // tells the compare unit this counter is its timebase
  always_ff @(posedge clk) begin
    if (reset) begin
      ccpUsesCounter <= 1'b0;
    end else begin
      ccpUsesCounter <= ctrl[CTL_TB_HI];
    end
  end

  // ------------------------------------------------------------------
  // interrupt flag, enable and output
  // ------------------------------------------------------------------
  // sticky flag, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ovfFlag <= 1'b0;
    end else if (overflow) begin
      ovfFlag <= 1'b1;
    end else if (hit(writeStrobe, address, OFF_FLAGS) && writeData[FLAG_OVF]) begin
      ovfFlag <= 1'b0;
    end
  end

  // enable register
  always_ff @(posedge clk) begin
    if (reset) begin
      ovfEnable <= 1'b0;
    end else if (hit(writeStrobe, address, OFF_ENABLES)) begin
      ovfEnable <= writeData[FLAG_OVF];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= ovfFlag && ovfEnable;
    end
  end

  // ------------------------------------------------------------------
  // pins
  // ------------------------------------------------------------------
  // direction and latch storage
  always_ff @(posedge clk) begin
    if (reset) begin
      pinDir   <= PINDIR_RESET;
      pinLatch <= 2'h0;
    end else begin
      if (hit(writeStrobe, address, OFF_PINDIR)) begin
        pinDir <= writeData[1:0];
      end
      if (hit(writeStrobe, address, OFF_PINDATA)) begin
        pinLatch <= writeData[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pinOe  <= '0;
      pinOut <= '0;
    end else begin
      pinOe.ext  <= !pinDir[PIN_EXT] && !oscEnable;
      pinOe.osc  <= !pinDir[PIN_OSC] && !oscEnable;
      pinOut.ext <= pinLatch[PIN_EXT];
      pinOut.osc <= pinLatch[PIN_OSC];
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  // read selection, unmapped bits read zero
  always_comb begin
    readMux = 8'h00;
    case (address)
      OFF_CTRL:      readMux = ctrl;
      OFF_LOW:       readMux = counterValue[7:0];
      // wide mode reads buffered high byte
      OFF_HIGH:      readMux = wideMode ? highBuf : counterValue[15:8];
      OFF_COMPANION: readMux = companion;
      OFF_FLAGS:     readMux = {6'h00, ovfFlag, 1'b0};
      OFF_ENABLES:   readMux = {6'h00, ovfEnable, 1'b0};
      OFF_PINDIR:    readMux = {6'h00, pinDir};
      OFF_PINDATA:   readMux = oscEnable ? 8'h00 : {6'h00, syncLevel};
      default:       readMux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      readData <= 8'h00;
    end else begin
      readData <= readStrobe ? readMux : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ==== tm3_timer_asserts.sv ====
// tm3_timer_asserts: port-level checks for the timer block
`default_nettype none
`timescale 1ns/1ps
module tm3_timer_asserts
  import tm3_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic              writeStrobe,
  input wire logic              readStrobe,
  input wire logic [DATA_W-1:0] readData,
  input wire logic [3:0]        ccpModeField,
  input wire logic              specialTrigger,
  input wire logic [15:0]       counterValue,
  input wire logic              ccpUsesCounter,
  input wire tm3_pins_t         pinIn,
  input wire tm3_pins_t         pinOut,
  input wire tm3_pins_t         pinOe,
  input wire logic              irq
);
  // ----------------------------------------------------------------
  // control bits mirrored from register writes
  // ----------------------------------------------------------------
  logic oscOn;   // oscillator enable as last written
  logic ctlOn;   // counter on bit as last written
  logic ctlWide; // wide access bit as last written
  always_ff @(posedge clk) begin
    if (reset) begin
      oscOn   <= 1'b0;
      ctlOn   <= 1'b0;
      ctlWide <= 1'b0;
    end else if (writeStrobe && address == OFF_COMPANION) begin
      oscOn <= writeData[COMP_OSCEN];
    end else if (writeStrobe && address == OFF_CTRL) begin
      ctlOn   <= writeData[CTL_ON];
      ctlWide <= writeData[CTL_WIDE];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  readIdle_a: assert property (!readStrobe |=> readData == 8'h00)
    else $error("read data not idle");
  trigClear_a: assert property (specialTrigger && ccpModeField == MODE_SPECIAL &&
    !(writeStrobe && (address == OFF_LOW || address == OFF_HIGH)) |=> counterValue == 16'h0000)
    else $error("trigger did not clear counter");
  trigWrite_a: assert property (specialTrigger && writeStrobe && address == OFF_LOW && !ctlWide
    |=> counterValue[7:0] == $past(writeData))
    else $error("write lost to trigger");
  countStep_a: assert property (!writeStrobe && !specialTrigger
    |=> 16'(counterValue - $past(counterValue)) <= 16'h0001)
    else $error("counter stepped by more than one");
  stopHold_a: assert property (!ctlOn && !writeStrobe && !specialTrigger |=> $stable(counterValue))
    else $error("counter moved while off");
  enIrqOff_a: assert property (writeStrobe && address == OFF_ENABLES && !writeData[FLAG_OVF]
    |=> ##1 !irq)
    else $error("irq with enable clear");
  flagClr_a: assert property (writeStrobe && address == OFF_FLAGS && writeData[FLAG_OVF] &&
    counterValue != COUNT_MAX |=> ##1 !irq)
    else $error("irq after flag clear");
  oscPins_a: assert property (oscOn |=> pinOe == '0)
    else $error("pin driven with oscillator on");
  oscRead_a: assert property (readStrobe && address == OFF_PINDATA && oscOn |=> readData == 8'h00)
    else $error("pin read not zero");
endmodule
`default_nettype wire
